// file: verilog/emc_pkg.sv
// Purpose: Constants and types shared by the energy manager register bank.
// Assumes: Registers are reached through an 8-bit serial-port register access path.
// Notes: Offsets are the serial register addresses; codes are raw field values.
// Notes on behaviour
// - The 4-bit warning threshold picks 2.4 V at code 0000 up to 4.3 V at code 1001, and resets to 0000.
// - Bit 4 of register 0x0B turns the early-warning comparator on when one and off when zero.
// - Bit 4 of register 0x0A leaves the regulated output high impedance when one and ties it to the battery input when zero.
// - The 6-bit profile takes register 7 bits 1:0 as its top bits and register 8 bits 7:4 as its low bits.
// - Profile zero means fixed mode using the fixed end-of-charge voltage, and 1 to 63 each pick a profile.
// - Margin codes 01, 10 and 11 give 2.19 V, 2.6 V and 2.95 V with 11 as default, and 00 must never be used.
// - The 32-bit energy count reads across addresses 0x01 to 0x04 with the most significant byte first.
// - The energy count clears to zero at the start of every new charge cycle.
// - The storage voltage reading follows the capacitor only in charge or active state.
// - The charge target reading loads once, on entry into the charge state.
// - Both readings use the 5-bit voltage code from below 1.1 V up to 5.54 V at 11111.
// - The charge target reading holds the comparator code for the selected fixed end-of-charge voltage.

`default_nettype none

package emc_pkg;

	// Register addresses on the serial port.
	localparam logic [7:0] EMC_ADDR_ENERGY3   = 8'h01;
	localparam logic [7:0] EMC_ADDR_ENERGY2   = 8'h02;
	localparam logic [7:0] EMC_ADDR_ENERGY1   = 8'h03;
	localparam logic [7:0] EMC_ADDR_ENERGY0   = 8'h04;
	localparam logic [7:0] EMC_ADDR_VSTORE    = 8'h05;
	localparam logic [7:0] EMC_ADDR_VTARGET   = 8'h06;
	localparam logic [7:0] EMC_ADDR_PROF_HI   = 8'h07;
	localparam logic [7:0] EMC_ADDR_CMD_PROF  = 8'h08;
	localparam logic [7:0] EMC_ADDR_OUT_SW    = 8'h0A;
	localparam logic [7:0] EMC_ADDR_WARN      = 8'h0B;
	localparam logic [7:0] EMC_ADDR_MARGIN    = 8'h0D;

	// Field positions.
	localparam int EMC_WARN_THR_LSB   = 0;
	localparam int EMC_WARN_EN_BIT    = 4;
	localparam int EMC_HIZ_BIT        = 4;
	localparam int EMC_PROF_HI_LSB    = 0;
	localparam int EMC_PROF_LO_LSB    = 4;
	localparam int EMC_MARGIN_LSB     = 0;

	// Reset values.
	localparam logic [3:0] EMC_WARN_THR_RST   = 4'h0;
	localparam logic       EMC_WARN_EN_RST    = 1'b0;
	localparam logic       EMC_HIZ_RST        = 1'b0;
	localparam logic [5:0] EMC_PROFILE_RST    = 6'h00;
	localparam logic [1:0] EMC_MARGIN_RST     = 2'h3;
	localparam logic [1:0] EMC_MARGIN_BAD     = 2'h0;
	localparam logic [7:0] EMC_RD_NONE        = 8'h00;

	// Highest defined warning threshold code; larger codes are stored as written and compare at its ladder step.
	localparam logic [3:0] EMC_WARN_THR_MAX   = 4'h9;

	// Charge-state of the power path, driven by the device sequencer.
	typedef enum logic [1:0]
	{
		EMC_ST_STANDBY = 2'b00,
		EMC_ST_CHARGE  = 2'b01,
		EMC_ST_ACTIVE  = 2'b10,
		EMC_ST_OFF     = 2'b11
	} emc_state_t;

endpackage

`default_nettype wire

// file: verilog/emc_regs.sv
// Purpose: Configuration and status register bank of the energy manager.
// Assumes: A serial decoder on clk presents one-cycle read and write strobes.
// Notes: The storage voltage code comes from the analog side and is synchronised.

`default_nettype none

module emc_regs
	import emc_pkg::*;
#(
	parameter int ENERGY_W = 32
)
(
	input  wire logic         clk,              // 200 MHz system clock.
	input  wire logic         reset_n,          // Asynchronous reset, active low.
	input  wire logic         reg_wr,           // One-cycle register write strobe.
	input  wire logic         reg_rd,           // One-cycle register read strobe.
	input  wire logic [7:0]   reg_addr,         // Register address.
	input  wire logic [7:0]   reg_wdata,        // Write data.
	output logic      [7:0]   reg_rdata,        // Read data, valid with reg_rvalid.
	output logic              reg_rvalid,       // One-cycle read answer pulse.
	input  wire emc_state_t   power_state,      // Sequencer state, same clock.
	input  wire logic         energy_tick,      // One-cycle fuel gauge increment.
	input  wire logic [4:0]   vstore_code_raw,  // Comparator ladder code, asynchronous.
	input  wire logic [3:0]   fixed_eoc_sel,    // Fixed end-of-charge voltage selection.
	output logic              warn_enable,      // Early-warning comparator enable.
	output logic      [3:0]   warn_threshold,   // Early-warning threshold selection.
	output logic              early_warning,    // Early-warning status indication.
	output logic              regulated_output_hiz, // Output switch high impedance.
	output logic      [5:0]   profile_number,   // Optimizer profile number.
	output logic              fixed_mode,       // High when profile number is zero.
	output logic      [1:0]   margin_sel        // Optimization margin selection.
);

	// Write-only configuration storage.
	logic [3:0]          warn_thr_ff;
	logic                warn_en_ff;
	logic                hiz_ff;
	logic [1:0]          prof_hi_ff;
	logic [3:0]          prof_lo_ff;
	logic [1:0]          margin_ff;

	// Status storage.
	logic [ENERGY_W-1:0] energy_ff;
	logic [23:0]         energy_shadow_ff;
	logic [4:0]          vstore_meta_ff;
	logic [4:0]          vstore_sync_ff;
	logic [4:0]          vstore_ff;
	logic [4:0]          vtarget_ff;
	emc_state_t          state_prev_ff;
	logic                early_warning_ff;
	logic                fixed_mode_ff;
	logic [7:0]          rdata_ff;
	logic                rvalid_ff;

	// Decoded strobes and next values.
	wire                 wr_prof_hi;
	wire                 wr_cmd;
	wire                 wr_out_sw;
	wire                 wr_warn;
	wire                 wr_margin;
	wire                 rd_msb;
	wire                 charge_entry;
	wire                 vstore_track;
	wire [5:0]           nxt_profile;
	wire [4:0]           warn_level;
	wire [4:0]           eoc_code;
	logic [7:0]          nxt_rdata;

	// Write decode; status addresses have no write strobe at all.
	assign wr_prof_hi   = reg_wr && (reg_addr == EMC_ADDR_PROF_HI);
	assign wr_cmd       = reg_wr && (reg_addr == EMC_ADDR_CMD_PROF);
	assign wr_out_sw    = reg_wr && (reg_addr == EMC_ADDR_OUT_SW);
	assign wr_warn      = reg_wr && (reg_addr == EMC_ADDR_WARN);
	assign wr_margin    = reg_wr && (reg_addr == EMC_ADDR_MARGIN)
		&& (reg_wdata[EMC_MARGIN_LSB +: 2] != EMC_MARGIN_BAD);
	assign rd_msb       = reg_rd && (reg_addr == EMC_ADDR_ENERGY3);

	// Charge entry is the first cycle the sequencer reports the charge state.
	assign charge_entry = (power_state == EMC_ST_CHARGE)
		&& (state_prev_ff != EMC_ST_CHARGE);
	assign nxt_profile  = {prof_hi_ff, prof_lo_ff};

	// Threshold voltage to ladder code; the ladder has no exact 2.8, 3.0,
	// 3.4 and 3.6 V steps, so the nearest ladder step is used.
	function automatic logic [4:0] warn_to_code(input logic [3:0] sel);
		logic [4:0] code;
		code = 5'h0D;
		case (sel)
			4'h0:    code = 5'h0D;   // 2.40 V.
			4'h1:    code = 5'h0E;   // 2.60 V.
			4'h2:    code = 5'h0F;   // 2.79 V.
			4'h3:    code = 5'h11;   // 3.01 V.
			4'h4:    code = 5'h12;   // 3.20 V.
			4'h5:    code = 5'h14;   // 3.41 V.
			4'h6:    code = 5'h16;   // 3.61 V.
			4'h7:    code = 5'h17;   // 3.84 V.
			4'h8:    code = 5'h18;   // 4.10 V.
			default: code = 5'h19;   // 4.33 V, also for undefined codes.
		endcase
		return code;
	endfunction

	// Fixed end-of-charge selection to ladder code. Selections below 0011
	// are undefined and give the lowest code, so a host that forgets to
	// program the field sees an obviously empty target.
	function automatic logic [4:0] eoc_to_code(input logic [3:0] sel);
		logic [4:0] code;
		code = 5'h00;
		case (sel)
			4'h3:    code = 5'h0E;   // 2.60 V.
			4'h4:    code = 5'h10;   // 2.95 V.
			4'h5:    code = 5'h13;   // 3.27 V.
			4'h6:    code = 5'h15;   // 3.57 V.
			4'h7:    code = 5'h17;   // 3.84 V.
			4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF:
				code = {1'b1, sel};  // 4.10 V to 5.54 V.
			default: code = 5'h00;
		endcase
		return code;
	endfunction

	assign warn_level   = warn_to_code(warn_thr_ff);
	assign eoc_code     = eoc_to_code(fixed_eoc_sel);

	// The storage reading tracks only while energy moves in or out.
	assign vstore_track = (power_state == EMC_ST_CHARGE)
		|| (power_state == EMC_ST_ACTIVE);

	// Read mux; write-only and unmapped addresses answer zero.
	always_comb
	begin
		nxt_rdata = EMC_RD_NONE;
		case (reg_addr)
			EMC_ADDR_ENERGY3: nxt_rdata = energy_ff[31:24];
			EMC_ADDR_ENERGY2: nxt_rdata = energy_shadow_ff[23:16];
			EMC_ADDR_ENERGY1: nxt_rdata = energy_shadow_ff[15:8];
			EMC_ADDR_ENERGY0: nxt_rdata = energy_shadow_ff[7:0];
			EMC_ADDR_VSTORE:  nxt_rdata = {3'h0, vstore_ff};
			EMC_ADDR_VTARGET: nxt_rdata = {3'h0, vtarget_ff};
			default:          nxt_rdata = EMC_RD_NONE;
		endcase
	end

	// Early-warning threshold and enable.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			warn_thr_ff <= EMC_WARN_THR_RST;
			warn_en_ff  <= EMC_WARN_EN_RST;
		end
		else if (wr_warn)
		begin
			warn_thr_ff <= reg_wdata[EMC_WARN_THR_LSB +: 4];
			warn_en_ff  <= reg_wdata[EMC_WARN_EN_BIT];
		end
	end

	// Output switch mode; other bits of this register belong elsewhere.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			hiz_ff <= EMC_HIZ_RST;
		else if (wr_out_sw)
			hiz_ff <= reg_wdata[EMC_HIZ_BIT];
	end

	// Profile halves; the low half shares its register with mode commands.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			prof_hi_ff <= EMC_PROFILE_RST[5:4];
			prof_lo_ff <= EMC_PROFILE_RST[3:0];
		end
		else
		begin
			if (wr_prof_hi)
				prof_hi_ff <= reg_wdata[EMC_PROF_HI_LSB +: 2];
			if (wr_cmd)
				prof_lo_ff <= reg_wdata[EMC_PROF_LO_LSB +: 4];
		end
	end

	// Fixed mode flag, registered so the output comes from a flip-flop.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			fixed_mode_ff <= 1'b1;
		else
			fixed_mode_ff <= (nxt_profile == EMC_PROFILE_RST);
	end

	// Margin; a write of the forbidden code keeps the old setting.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			margin_ff <= EMC_MARGIN_RST;
		else if (wr_margin)
			margin_ff <= reg_wdata[EMC_MARGIN_LSB +: 2];
	end

	// Two-flop synchroniser for the ladder code. The ladder moves one step
	// at a time and far slower than clk, so a word crossing is safe here.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			vstore_meta_ff <= 5'h00;
			vstore_sync_ff <= 5'h00;
		end
		else
		begin
			vstore_meta_ff <= vstore_code_raw;
			vstore_sync_ff <= vstore_meta_ff;
		end
	end

	// Storage reading, frozen in standby so leakage decay is not shown.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			vstore_ff <= 5'h00;
		else if (vstore_track)
			vstore_ff <= vstore_sync_ff;
	end

	// Previous state and the target reading captured on charge entry.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_prev_ff <= EMC_ST_STANDBY;
			vtarget_ff    <= 5'h00;
		end
		else
		begin
			state_prev_ff <= power_state;
			if (charge_entry)
				vtarget_ff <= eoc_code;
		end
	end

	// Fuel gauge; a tick in the clearing cycle belongs to the new cycle.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			energy_ff <= '0;
		else if (charge_entry)
			energy_ff <= energy_tick ? ENERGY_W'(1) : '0;
		else if (energy_tick)
			energy_ff <= energy_ff + ENERGY_W'(1);
	end

	// Reading the top byte freezes the rest, so a four-byte read in
	// address order is coherent even while the gauge keeps counting.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			energy_shadow_ff <= 24'h000000;
		else if (rd_msb)
			energy_shadow_ff <= energy_ff[23:0];
	end

	// Early warning compares the live synchronised code, not the frozen one.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			early_warning_ff <= 1'b0;
		else
			early_warning_ff <= warn_en_ff
				&& (vstore_sync_ff < warn_level);
	end

	// Read answer one cycle after the strobe.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rdata_ff  <= EMC_RD_NONE;
			rvalid_ff <= 1'b0;
		end
		else
		begin
			rvalid_ff <= reg_rd;
			if (reg_rd)
				rdata_ff <= nxt_rdata;
		end
	end

	// Outputs, each straight from a flip-flop.
	assign reg_rdata            = rdata_ff;
	assign reg_rvalid           = rvalid_ff;
	assign warn_enable          = warn_en_ff;
	assign warn_threshold       = warn_thr_ff;
	assign early_warning        = early_warning_ff;
	assign regulated_output_hiz = hiz_ff;
	assign profile_number       = {prof_hi_ff, prof_lo_ff};
	assign fixed_mode           = fixed_mode_ff;
	assign margin_sel           = margin_ff;

endmodule

`default_nettype wire

// file: sim/emc_regs_properties.sv
// Purpose: Port checks of the energy manager register bank.
// Assumes: One clock domain; reset_n loads every register with its reset value.
// Notes: Write effects are checked one edge after the strobe.
`default_nettype none
module emc_regs_properties
	import emc_pkg::*;
#(
	parameter int ENERGY_W = 32
)
(
	input wire logic       clk,                  // Clock.
	input wire logic       reset_n,              // Reset, active low.
	input wire logic       reg_wr,               // Write strobe.
	input wire logic       reg_rd,               // Read strobe.
	input wire logic [7:0] reg_addr,             // Address.
	input wire logic [7:0] reg_wdata,            // Write data.
	input wire logic [7:0] reg_rdata,            // Read data.
	input wire logic       reg_rvalid,           // Read answer.
	input wire logic       warn_enable,          // Warning enable.
	input wire logic [3:0] warn_threshold,       // Warning threshold.
	input wire logic       early_warning,        // Warning flag.
	input wire logic       regulated_output_hiz, // Output switch.
	input wire logic [5:0] profile_number,       // Profile.
	input wire logic       fixed_mode,           // Fixed mode.
	input wire logic [1:0] margin_sel            // Margin.
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] wdata_ff;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Write decodes, so each check below reads as cause and effect.
	wire wr_warn = reg_wr && reg_addr == EMC_ADDR_WARN;
	wire wr_sw   = reg_wr && reg_addr == EMC_ADDR_OUT_SW;
	wire wr_phi  = reg_wr && reg_addr == EMC_ADDR_PROF_HI;
	wire wr_plo  = reg_wr && reg_addr == EMC_ADDR_CMD_PROF;
	wire wr_marg = reg_wr && reg_addr == EMC_ADDR_MARGIN;
	wire rd_wo   = reg_rd && reg_addr inside {8'h07, 8'h08, 8'h0A, 8'h0B, 8'h0D};
	// Keeps the write data of the last edge, since $past takes a whole signal only.
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
			wdata_ff <= 8'h00;
		else
			wdata_ff <= reg_wdata;
	a_thr_write: assert property (wr_warn |=> warn_threshold == wdata_ff[3:0])
		else $error("threshold differs from write");
	a_warn_enable: assert property (wr_warn |=> warn_enable == wdata_ff[4])
		else $error("warning enable differs from write");
	a_hiz_write: assert property (wr_sw |=> regulated_output_hiz == wdata_ff[4])
		else $error("output switch differs from write");
	a_prof_high: assert property (wr_phi |=> profile_number[5:4] == wdata_ff[1:0])
		else $error("profile upper bits differ");
	a_prof_low: assert property (wr_plo |=> profile_number[3:0] == wdata_ff[7:4])
		else $error("profile lower bits differ");
	a_fixed_mode: assert property (fixed_mode == ($past(profile_number) == 6'h00))
		else $error("fixed mode wrong");
	a_margin_set: assert property (wr_marg && reg_wdata[1:0] != 2'h0 |=> margin_sel == wdata_ff[1:0])
		else $error("margin differs from write");
	a_margin_keep: assert property (wr_marg && reg_wdata[1:0] == 2'h0 |=> $stable(margin_sel))
		else $error("margin changed by code zero");
	a_margin_legal: assert property (margin_sel != EMC_MARGIN_BAD)
		else $error("margin holds code zero");
	a_wo_read: assert property (rd_wo |=> reg_rvalid && reg_rdata == EMC_RD_NONE)
		else $error("write-only read not zero");
	a_rd_pulse: assert property (reg_rvalid |-> $past(reg_rd))
		else $error("read answer without request");
	a_warn_off: assert property (!warn_enable [*4] |-> !early_warning)
		else $error("warning while disabled");
	c_margin_zero: cover property (wr_marg && reg_wdata[1:0] == 2'h0);
	c_warning: cover property (early_warning);
	c_read_data: cover property (reg_rvalid && reg_rdata != 8'h00);
endmodule
bind emc_regs emc_regs_properties #(.ENERGY_W(ENERGY_W)) chk
(
	.clk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
	.warn_enable, .warn_threshold, .early_warning, .regulated_output_hiz,
	.profile_number, .fixed_mode, .margin_sel
);
`default_nettype wire

// file: sim/emc_host_model.sv
// Purpose: Host model that issues register strobes to the bank.
// Assumes: Strobes change at the falling edge and stand for one rising edge.
// Notes: Read expectations are queued here for the bench monitor.
`default_nettype none
module emc_host_model
(
	input  wire logic       clk,       // Bench clock.
	output var  logic       reg_wr,    // Write strobe.
	output var  logic       reg_rd,    // Read strobe.
	output var  logic [7:0] reg_addr,  // Address.
	output var  logic [7:0] reg_wdata  // Write data.
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] exp_q [$];
	// Idle bus starts parked; after a transfer it shows the inverse address, and after a write also the inverse data.
	initial
	begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'hA5;
		reg_wdata = 8'h5A;
	end
	// Profile halves go as two writes; margin code zero only when a scenario asks.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(negedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	// A read notes its expected answer before the strobe goes out.
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		exp_q.push_back(e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(negedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
	endtask
endmodule
`default_nettype wire

// file: sim/tb_energy_manager_config_status_regs.sv
// Purpose: Self-checking bench of the energy manager register bank.
// Assumes: The host model owns the strobes and the queue of read notes.
// Notes: Status inputs change at the falling edge.
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
	$display("wrong value at %0t: got %h want %h", $time, (a), (b)); end end
module tb_energy_manager_config_status_regs;
	import emc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk = 1'b0;
	logic       reset_n = 1'b0;
	logic       reg_wr, reg_rd, reg_rvalid, energy_tick, warn_enable, early_warning;
	logic       regulated_output_hiz, fixed_mode;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d, exp_rd;
	logic [4:0] vstore_code_raw, r;
	logic [3:0] fixed_eoc_sel, warn_threshold;
	logic [5:0] profile_number;
	logic [1:0] margin_sel;
	emc_state_t power_state;
	int         num_errors = 0;
	int         compares = 0;
	int         a;
	integer     seed = 32'h8EB91171;
	logic [7:0] eoc_tab [16] = '{8'h00, 8'h00, 8'h00, 8'h0E, 8'h10, 8'h13, 8'h15, 8'h17,
		8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h1F};
	logic [4:0] ew_raw [4] = '{5'h13, 5'h14, 5'h00, 5'h00};
	always #2.5 clk = ~clk;
	emc_host_model host (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
	emc_regs DUT (.clk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
		.reg_rvalid, .power_state, .energy_tick, .vstore_code_raw, .fixed_eoc_sel,
		.warn_enable, .warn_threshold, .early_warning, .regulated_output_hiz,
		.profile_number, .fixed_mode, .margin_sel);
	// Each read answer takes the oldest note; mid-cycle sampling avoids edge races.
	// The note is popped once into exp_rd, since the macro names its operands twice.
	always @(negedge clk)
		if (reg_rvalid === 1'b1)
		begin
			if (host.exp_q.size() == 0)
			begin
				num_errors++;
				$display("wrong value at %0t: read answer with no note", $time);
			end
			else
			begin
				exp_rd = host.exp_q.pop_front();
				`CHK(reg_rdata, exp_rd)
			end
		end
	task automatic complete_run();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic go(input emc_state_t s, input int n);
		@(negedge clk);
		power_state = s;
		repeat (n) @(negedge clk);
	endtask
	task automatic chk_energy(input logic [31:0] e);
		for (int i = 0; i < 4; i++)
			host.rd(EMC_ADDR_ENERGY3 + i[7:0], e[31 - 8 * i -: 8]);
	endtask
	// The fixed end-of-charge selection starts defined; the target loop also drives the undefined selections.
	initial
	begin
		power_state = EMC_ST_STANDBY;
		energy_tick = 1'b0;
		vstore_code_raw = 5'h00;
		fixed_eoc_sel = 4'h9;
		repeat (10) @(posedge clk);
		@(negedge clk);
		reset_n = 1'b1;
		`CHK({warn_enable, warn_threshold, margin_sel}, 7'h03)
		`CHK({regulated_output_hiz, fixed_mode, profile_number}, 8'h40)
		for (a = 1; a < 7; a++)
			host.wr(a[7:0], $random(seed));
		for (a = 0; a < 17; a++)
			host.rd((a == 16) ? 8'hFF : a[7:0], 8'h00);
		// Random settings, with profile zero first; threshold stays in the defined range.
		for (a = 0; a < 8; a++)
		begin
			d = a ? $random(seed) : 8'h00;
			d[3:0] = d[3:0] % 4'hA;
			host.wr(EMC_ADDR_WARN, d);
			host.wr(EMC_ADDR_OUT_SW, d);
			host.wr(EMC_ADDR_PROF_HI, d);
			host.wr(EMC_ADDR_CMD_PROF, d);
			`CHK({warn_enable, warn_threshold}, d[4:0])
			`CHK(regulated_output_hiz, d[4])
			`CHK(profile_number, {d[1:0], d[7:4]})
			@(negedge clk);
			`CHK(fixed_mode, d[1:0] == 2'h0 && d[7:4] == 4'h0)
			host.rd(EMC_ADDR_WARN, 8'h00);
		end
		for (a = 0; a < 4; a++)
		begin
			host.wr(EMC_ADDR_MARGIN, {6'h2A, a[1:0]});
			`CHK(margin_sel, (a == 0) ? 2'h3 : a[1:0])
		end
		// Selection moves after entry, so a reload outside entry shows up.
		for (a = 0; a < 16; a++)
		begin
			fixed_eoc_sel = a[3:0];
			go(EMC_ST_STANDBY, 2);
			go(EMC_ST_CHARGE, 2);
			fixed_eoc_sel = ~a[3:0];
			host.rd(EMC_ADDR_VTARGET, eoc_tab[a]);
		end
		d = $random(seed);
		r = d[4:0];
		vstore_code_raw = r;
		repeat (4) @(negedge clk);
		host.rd(EMC_ADDR_VSTORE, {3'h0, r});
		go(EMC_ST_STANDBY, 1);
		vstore_code_raw = ~r;
		repeat (4) @(negedge clk);
		host.rd(EMC_ADDR_VSTORE, {3'h0, r});
		go(EMC_ST_ACTIVE, 4);
		host.rd(EMC_ADDR_VSTORE, {3'h0, ~r});
		// Threshold code 5 sits at ladder 14; equal must not warn.
		for (a = 0; a < 4; a++)
		begin
			host.wr(EMC_ADDR_WARN, {3'h0, a != 3, 4'h5});
			vstore_code_raw = ew_raw[a];
			repeat (4) @(negedge clk);
			`CHK(early_warning, a != 3 && ew_raw[a] < 5'h14)
		end
		go(EMC_ST_CHARGE, 1);
		energy_tick = 1'b1;
		repeat (511) @(negedge clk);
		energy_tick = 1'b0;
		chk_energy(32'h000001FF);
		go(EMC_ST_STANDBY, 1);
		go(EMC_ST_CHARGE, 1);
		chk_energy(32'h00000000);
		for (a = 0; a < 10 && host.exp_q.size() > 0; a++)
			@(negedge clk);
		if (host.exp_q.size() > 0)
		begin
			num_errors++;
			$display("wrong value at %0t: read answers missing", $time);
		end
		complete_run();
	end
endmodule
`default_nettype wire
